// ---- rtl/bdap_regs.sv ----
/*
 * Device-specific configuration registers: diagnostic, arbiter, read control.
 * Assumes type-0 config accesses already decoded, one request per cycle.
 */
module bdap_regs (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Configuration access
	input wire bdap_pkg::bdap_cfg_req_t cfg_req,
	output logic [31:0] cfg_rdata,
	// Bridge state
	input wire logic bridge_sec_reset_bit,
	input wire logic [7:0] ds_line_size,
	input wire logic [7:0] us_line_size,
	input wire logic primary_posted_write,
	// Chip reset controls
	output logic chip_reset,
	output logic set_sec_reset_bit,
	output logic sec_rst_n,
	// Block controls
	output bdap_pkg::bdap_cfg_t cfg,
	output logic [bdap_pkg::BDAP_NUM_REQ-1:0] req_high_group,
	output logic bridge_high_group,
	output logic [6:0] ds_limit_dw,
	output logic ds_to_line,
	output logic [6:0] us_limit_dw,
	output logic us_to_line,
	output logic flush_primary_completions
);
	import bdap_pkg::*;
	typedef enum {BDAP_IDLE, BDAP_RESETTING} bdap_state_t;

	bdap_state_t state_reg, state_next;
	logic [4:0] cnt_reg, cnt_next;
	bdap_cfg_t cfg_reg, cfg_next;
	logic [31:0] rdata_reg, rdata_next;
	logic flush_reg, flush_next;
	logic wr_diag, wr_arb_lo, wr_arb_hi, wr_rd;
	logic hit_diag, hit_rd;
	logic chip_reset_req;
	logic local_reset;

	assign hit_diag = cfg_req.valid && cfg_req.offset == BDAP_OFF_DIAG_ARB;
	assign hit_rd = cfg_req.valid && cfg_req.offset == BDAP_OFF_READ_CTL;
	assign wr_diag = hit_diag && cfg_req.write && !cfg_req.cbe_n[1];
	assign wr_arb_lo = hit_diag && cfg_req.write && !cfg_req.cbe_n[2];
	assign wr_arb_hi = hit_diag && cfg_req.write && !cfg_req.cbe_n[3];
	assign wr_rd = hit_rd && cfg_req.write && !cfg_req.cbe_n[0];
	assign chip_reset_req = wr_diag && cfg_req.wdata[BDAP_CHIP_RESET_BIT];
	assign local_reset = srst || state_reg == BDAP_RESETTING;

	// Chip reset sequencer
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		case (state_reg)
			BDAP_IDLE: begin
				if (chip_reset_req) begin
					state_next = BDAP_RESETTING;
					cnt_next = 5'(BDAP_CHIP_RESET_CYCLES - 1);
				end
			end
			BDAP_RESETTING: begin
				if (cnt_reg == 5'h00) begin
					state_next = BDAP_IDLE;
				end else begin
					cnt_next = 5'(cnt_reg - 5'h01);
				end
			end
			default: begin
				state_next = BDAP_IDLE;
				cnt_next = 5'h00;
			end
		endcase
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			state_reg <= BDAP_IDLE;
			cnt_reg <= 5'h00;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
		end
	end

	// Field registers
	always_comb begin
		cfg_next = cfg_reg;
		if (wr_diag) begin
			cfg_next.test_mode = cfg_req.wdata[BDAP_TEST_LO +: 2];
		end
		if (wr_arb_lo) begin
			cfg_next.arb_high[7:0] = cfg_req.wdata[BDAP_ARB_LO +: 8];
		end
		if (wr_arb_hi) begin
			cfg_next.arb_high[9:8] = cfg_req.wdata[BDAP_ARB_LO + 8 +: 2];
		end
		if (wr_rd) begin
			cfg_next.ds_count = cfg_req.wdata[BDAP_DS_COUNT_LO +: 2];
			cfg_next.us_count = cfg_req.wdata[BDAP_US_COUNT_LO +: 2];
			cfg_next.ds_cl_en = cfg_req.wdata[BDAP_DS_CL_BIT];
			cfg_next.us_cl_en = cfg_req.wdata[BDAP_US_CL_BIT];
			cfg_next.np_flush = cfg_req.wdata[BDAP_FLUSH_BIT];
		end
	end
	always_ff @(posedge clk) begin
		if (local_reset) begin
			cfg_reg.test_mode <= BDAP_TEST_RESET;
			cfg_reg.arb_high <= BDAP_ARB_RESET;
			cfg_reg.ds_count <= BDAP_COUNT_RESET;
			cfg_reg.us_count <= BDAP_COUNT_RESET;
			cfg_reg.ds_cl_en <= BDAP_CL_RESET;
			cfg_reg.us_cl_en <= BDAP_CL_RESET;
			cfg_reg.np_flush <= BDAP_FLUSH_RESET;
		end else begin
			cfg_reg <= cfg_next;
		end
	end

	// Read data, cleared byte lanes of disabled enables
	always_comb begin
		rdata_next = 32'h0000_0000;
		if (hit_diag && !cfg_req.write) begin
			if (!cfg_req.cbe_n[1]) begin
				rdata_next[BDAP_CHIP_RESET_BIT] = state_reg == BDAP_RESETTING;
				rdata_next[BDAP_TEST_LO +: 2] = cfg_reg.test_mode;
			end
			if (!cfg_req.cbe_n[2]) begin
				rdata_next[BDAP_ARB_LO +: 8] = cfg_reg.arb_high[7:0];
			end
			if (!cfg_req.cbe_n[3]) begin
				rdata_next[BDAP_ARB_LO + 8 +: 2] = cfg_reg.arb_high[9:8];
			end
		end else if (hit_rd && !cfg_req.write && !cfg_req.cbe_n[0]) begin
			rdata_next[BDAP_DS_COUNT_LO +: 2] = cfg_reg.ds_count;
			rdata_next[BDAP_US_COUNT_LO +: 2] = cfg_reg.us_count;
			rdata_next[BDAP_DS_CL_BIT] = cfg_reg.ds_cl_en;
			rdata_next[BDAP_US_CL_BIT] = cfg_reg.us_cl_en;
			rdata_next[BDAP_FLUSH_BIT] = cfg_reg.np_flush;
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_reg <= 32'h0000_0000;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	// Completion flush strobe
	always_comb begin
		flush_next = cfg_reg.np_flush && primary_posted_write && !local_reset;
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			flush_reg <= 1'b0;
		end else begin
			flush_reg <= flush_next;
		end
	end

	// Per-direction prefetch limits
	for (genvar d = 0; d < 2; d++) begin : g_dir
		bdap_pf_in_t pf_in;
		logic [6:0] lim;
		logic tl;
		assign pf_in = (d == 0) ? {cfg_reg.ds_cl_en, cfg_reg.ds_count, ds_line_size}
			: {cfg_reg.us_cl_en, cfg_reg.us_count, us_line_size};
		bdap_prefetch_limit u_lim (
			.clk(clk),
			.srst(local_reset),
			.pf(pf_in),
			.limit_dw(lim),
			.to_line(tl)
		);
	end
	assign ds_limit_dw = g_dir[0].lim;
	assign ds_to_line = g_dir[0].tl;
	assign us_limit_dw = g_dir[1].lim;
	assign us_to_line = g_dir[1].tl;

	assign cfg_rdata = rdata_reg;
	assign cfg = cfg_reg;
	assign req_high_group = cfg_reg.arb_high[BDAP_NUM_REQ-1:0];
	assign bridge_high_group = cfg_reg.arb_high[BDAP_ARB_BRIDGE_BIT];
	assign chip_reset = state_reg == BDAP_RESETTING;
	assign set_sec_reset_bit = chip_reset;
	assign sec_rst_n = !(chip_reset || bridge_sec_reset_bit);
	assign flush_primary_completions = flush_reg;
endmodule : bdap_regs

// ---- include/bdap_pkg.sv ----
/*
 * Constants and carrier types for the bridge device-specific registers.
 * Assumes a configuration access port decoded from the primary bus.
 */
// What this block does
// - Writing one to chip reset starts reset
// - Chip reset restores buffers, registers, both interfaces
// - Chip reset bit self-clears when reset completes
// - Chip reset asserts secondary reset and bit
// - Test field selects exercised counter bytes; this block only stores it, reads it back and drives it out on cfg
// - Reserved bits read only, return zero
// - Priority bits map to requests, bit 25 bridge
// - Zero means low group, one means high
// - Reset priority: bridge high, others low
// - Two-bit prefetch count per direction, 16-64 dwords
// - Downstream cacheline prefetch to boundary, resets one
// - Upstream cacheline prefetch to boundary, resets one
// - Disabled cacheline prefetch uses maximum count
// - Flush drops primary completions on posted write
// - Flush clear keeps standard ordering rules
package bdap_pkg;
	localparam logic [7:0] BDAP_OFF_DIAG_ARB = 8'h40;
	localparam logic [7:0] BDAP_OFF_READ_CTL = 8'h44;
	localparam int BDAP_CHIP_RESET_BIT = 8;
	localparam int BDAP_TEST_LO = 9;
	localparam int BDAP_ARB_LO = 16;
	localparam int BDAP_ARB_BRIDGE_BIT = 9;
	localparam int BDAP_NUM_REQ = 9;
	localparam int BDAP_DS_COUNT_LO = 6;
	localparam int BDAP_US_COUNT_LO = 4;
	localparam int BDAP_DS_CL_BIT = 2;
	localparam int BDAP_US_CL_BIT = 1;
	localparam int BDAP_FLUSH_BIT = 0;
	localparam logic [1:0] BDAP_TEST_RESET = 2'h0;
	localparam logic [9:0] BDAP_ARB_RESET = 10'h200;
	localparam logic [1:0] BDAP_COUNT_RESET = 2'h0;
	localparam logic BDAP_CL_RESET = 1'b1;
	localparam logic BDAP_FLUSH_RESET = 1'b0;
	localparam logic [6:0] BDAP_DW_PER_STEP = 7'h10;
	localparam logic [7:0] BDAP_DEFAULT_LINE_BYTES = 8'h40;
	localparam int BDAP_CHIP_RESET_CYCLES = 16;

	typedef struct packed {
		logic valid;
		logic write;
		logic [7:0] offset;
		logic [3:0] cbe_n;
		logic [31:0] wdata;
	} bdap_cfg_req_t;

	typedef struct packed {
		logic [1:0] test_mode;
		logic [9:0] arb_high;
		logic [1:0] ds_count;
		logic [1:0] us_count;
		logic ds_cl_en;
		logic us_cl_en;
		logic np_flush;
	} bdap_cfg_t;

	typedef struct packed {
		logic cl_en;
		logic [1:0] max_count;
		logic [7:0] line_size;
	} bdap_pf_in_t;
endpackage : bdap_pkg

// ---- rtl/bdap_prefetch_limit.sv ----
/*
 * Prefetch limit for one direction of memory reads.
 * Assumes cacheline size given in dwords, zero meaning not programmed.
 */
module bdap_prefetch_limit (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Direction controls
	input wire bdap_pkg::bdap_pf_in_t pf,
	// Limit out
	output logic [6:0] limit_dw,
	output logic to_line
);
	import bdap_pkg::*;
	logic [6:0] limit_next;
	logic to_line_next;
	logic [6:0] limit_reg;
	logic to_line_reg;
	always_comb begin
		to_line_next = pf.cl_en;
		if (pf.cl_en) begin
			if (pf.line_size == 8'h00) begin
				limit_next = 7'(BDAP_DEFAULT_LINE_BYTES >> 2);
			end else begin
				limit_next = pf.line_size[6:0];
			end
		end else begin
			limit_next = 7'(({5'h00, pf.max_count} + 7'h01) * BDAP_DW_PER_STEP);
		end
	end
	always_ff @(posedge clk) begin
		if (srst) begin
			limit_reg <= 7'(BDAP_DEFAULT_LINE_BYTES >> 2);
			to_line_reg <= BDAP_CL_RESET;
		end else begin
			limit_reg <= limit_next;
			to_line_reg <= to_line_next;
		end
	end
	assign limit_dw = limit_reg;
	assign to_line = to_line_reg;
endmodule : bdap_prefetch_limit

// ---- bench/bdap_brctl_model.sv ----
/* Model of the bridge control secondary-reset bit.
   Assumes set by the block, cleared by a software write. */
module bdap_brctl_model (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Set and clear
	input wire logic set_bit,
	input wire logic sw_clear,
	output logic sec_bit_reg
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sec_bit_next;
	always_comb begin
		sec_bit_next = sec_bit_reg;
		if (sw_clear) sec_bit_next = 1'b0;
		if (set_bit) sec_bit_next = 1'b1;
	end
	always_ff @(posedge clk) sec_bit_reg <= srst ? 1'b0 : sec_bit_next;
endmodule : bdap_brctl_model

// ---- bench/bdap_regs_chk.sv ----
/* Assertions on the register block.
   Assumes bound to bdap_regs, one clock. */
module bdap_regs_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Access
	input wire bdap_pkg::bdap_cfg_req_t cfg_req,
	input wire logic [31:0] cfg_rdata,
	input wire logic primary_posted_write,
	// Results
	input wire logic chip_reset,
	input wire logic set_sec_reset_bit,
	input wire logic sec_rst_n,
	input wire bdap_pkg::bdap_cfg_t cfg,
	input wire logic [8:0] req_high_group,
	input wire logic bridge_high_group,
	input wire logic [6:0] ds_limit_dw,
	input wire logic flush_primary_completions
);
	timeunit 1ns;
	timeprecision 1ns;
	import bdap_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	wire cr_wr = cfg_req.valid && cfg_req.write && cfg_req.offset == 8'h40 && !cfg_req.cbe_n[1];
	property p_go; cr_wr && cfg_req.wdata[8] && !chip_reset |=> chip_reset; endproperty
	a_go: assert property (p_go) else $error("no chip reset");
	property p_len; $rose(chip_reset) |-> ##15 chip_reset ##1 !chip_reset; endproperty
	a_len: assert property (p_len) else $error("bad reset length");
	property p_clr; chip_reset && $past(chip_reset) |-> cfg.arb_high == 10'h200 && cfg.ds_cl_en;
	endproperty
	a_clr: assert property (p_clr) else $error("cfg not reset");
	property p_sec; chip_reset |-> !sec_rst_n && set_sec_reset_bit; endproperty
	a_sec: assert property (p_sec) else $error("sec reset off");
	property p_map; cfg_req.valid && cfg_req.write && cfg_req.offset == 8'h40 &&
		cfg_req.cbe_n[3:2] == 2'h0 && !chip_reset |=>
		{bridge_high_group, req_high_group} == $past(cfg_req.wdata[25:16]); endproperty
	a_map: assert property (p_map) else $error("group map");
	property p_fl; cfg.np_flush && primary_posted_write && !chip_reset |=>
		flush_primary_completions; endproperty
	a_fl: assert property (p_fl) else $error("no flush");
	property p_nofl; !(cfg.np_flush && primary_posted_write) |=> !flush_primary_completions;
	endproperty
	a_nofl: assert property (p_nofl) else $error("stray flush");
	property p_rsv; cfg_rdata[31:26] == 6'h00 && cfg_rdata[15:11] == 5'h00; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved set");
	property p_lim; !cfg.ds_cl_en |=>
		chip_reset || ds_limit_dw == {{1'b0, $past(cfg.ds_count)} + 3'h1, 4'h0}; endproperty
	a_lim: assert property (p_lim) else $error("ds limit");
	c_cr: cover property ($rose(chip_reset));
	c_fl: cover property (flush_primary_completions);
	c_lim: cover property (!cfg.ds_cl_en && cfg.ds_count == 2'h3);
endmodule : bdap_regs_chk
bind bdap_regs bdap_regs_chk bdap_regs_chk_i (.clk(clk), .srst(srst), .cfg_req(cfg_req),
	.cfg_rdata(cfg_rdata), .primary_posted_write(primary_posted_write),
	.chip_reset(chip_reset), .set_sec_reset_bit(set_sec_reset_bit), .sec_rst_n(sec_rst_n),
	.cfg(cfg), .req_high_group(req_high_group), .bridge_high_group(bridge_high_group),
	.ds_limit_dw(ds_limit_dw), .flush_primary_completions(flush_primary_completions));

// ---- bench/bdap_regs_bench.sv ----
/* Self-checking bench for the register block.
   Assumes the package and the bridge control model compiled first. */
module bdap_regs_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import bdap_pkg::*;
	logic clk = 1'b0, srst = 1'b1, ppw = 1'b0, sw_clr = 1'b0;
	bdap_cfg_req_t req = '0;
	logic [7:0] ds_ls = 8'h00;
	logic [31:0] q, rd_seen;
	logic cr, ssb, srn, sb, bhg;
	logic [8:0] rhg;
	logic [6:0] dl, ul;
	logic flush, dtl, utl;
	bdap_cfg_t cfg;
	int err_total = 0, samples_checked = 0, i;
	always #10 clk = ~clk;
	bdap_regs bdap_regs_i (.clk(clk), .srst(srst), .cfg_req(req), .cfg_rdata(q),
		.bridge_sec_reset_bit(sb), .ds_line_size(ds_ls), .us_line_size(8'h00),
		.primary_posted_write(ppw), .chip_reset(cr), .set_sec_reset_bit(ssb),
		.sec_rst_n(srn), .cfg(cfg), .req_high_group(rhg), .bridge_high_group(bhg),
		.ds_limit_dw(dl), .ds_to_line(dtl), .us_limit_dw(ul), .us_to_line(utl),
		.flush_primary_completions(flush));
	bdap_brctl_model bdap_brctl_model_i (.clk(clk), .srst(srst), .set_bit(ssb),
		.sw_clear(sw_clr), .sec_bit_reg(sb));
	task report_and_stop;
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : report_and_stop
	task chk(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task cyc(input int n);
		repeat (n) @(posedge clk);
		#2;
	endtask : cyc
	task acc(input logic w, input logic [7:0] o, input logic [3:0] b, input logic [31:0] d);
		req = {1'b1, w, o, b, d};
		cyc(1);
		rd_seen = q;
		req.valid = 1'b0;
		cyc(1);
	endtask : acc
	task rd(input string n, input logic [7:0] o, input logic [3:0] b, input logic [31:0] e);
		acc(1'b0, o, b, 32'h0);
		chk(n, e, rd_seen);
	endtask : rd
	initial begin
		#100000;
		err_total++;
		report_and_stop;
	end
	initial begin
		cyc(16);
		srst = 1'b0;
		rd("arb", 8'h40, 4'h0, 32'h0200_0000);
		rd("rctl", 8'h44, 4'h0, 32'h0000_0006);
		chk("grp", 32'h200, {22'h0, bhg, rhg});
		acc(1'b1, 8'h40, 4'h0, 32'hFFFF_FEFF);
		chk("nocr", 32'h0, {31'h0, cr});
		rd("all", 8'h40, 4'h0, 32'h03FF_0600);
		acc(1'b1, 8'h40, 4'hB, 32'h0);
		rd("lane", 8'h40, 4'h0, 32'h0300_0600);
		for (i = 0; i < 4; i++) begin
			acc(1'b1, 8'h40, 4'hD, 32'h200 * i);
			rd("test", 8'h40, 4'hD, 32'h200 * i);
			acc(1'b1, 8'h44, 4'hE, 32'h50 * i);
			chk("dlim", 32'h10 * (i + 1), {25'h0, dl});
			chk("ulim", 32'h10 * (i + 1), {25'h0, ul});
			chk("tl_off", 32'h0, {30'h0, dtl, utl});
		end
		ds_ls = 8'h08;
		acc(1'b1, 8'h44, 4'hE, 32'h6);
		chk("dline", 32'h8, {25'h0, dl});
		chk("uline", 32'h10, {25'h0, ul});
		chk("tl_on", 32'h3, {30'h0, dtl, utl});
		for (i = 1; i >= 0; i--) begin
			acc(1'b1, 8'h44, 4'hE, 32'h1 * i);
			ppw = 1'b1;
			cyc(1);
			ppw = 1'b0;
			chk("flush", 32'h1 * i, {31'h0, flush});
		end
		acc(1'b1, 8'h48, 4'h0, 32'hFFFF_FFFF);
		rd("unmap", 8'h48, 4'h0, 32'h0);
		acc(1'b1, 8'h40, 4'hD, 32'h100);
		chk("crst", 32'h5, {29'h0, cr, srn, sb});
		for (i = 0; i < 40 && cr !== 1'b0; i++) cyc(1);
		if (cr !== 1'b0) begin
			err_total++;
			report_and_stop;
		end
		rd("done", 8'h40, 4'h0, 32'h0200_0000);
		chk("held", 32'h0, {31'h0, srn});
		sw_clr = 1'b1;
		cyc(1);
		sw_clr = 1'b0;
		chk("rel", 32'h1, {31'h0, srn});
		report_and_stop;
	end
endmodule : bdap_regs_bench
